// ==== fcs_params.svh ====
// constants for the flash command sequencer
// assumes inclusion by fcs_map, fcs_seq and fcs_seq_props
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CMD_SINGLE_HI 12'h55A
`define FCS_CMD_DOUBLE_HI 12'hDD4
`define FCS_CMD_BLOCK_HI 12'hAA5
`define FCS_CMD_ERASE 16'hEEEE
`define FCS_ERASE_KEY 16'h5555
`define FCS_CMD_STATUS 16'h7777
`define FCS_RES_OK 8'h00
`define FCS_RES_NOVPP 8'h02
`define FCS_RES_PROG_FAIL 8'h03
`define FCS_RES_BAD_ADDR 8'h04
`define FCS_RES_BAD_PERIOD 8'h05
`define FCS_RES_BAD_BANK 8'h07
`define FCS_RES_ERASE_FAIL 8'h08
`define FCS_RES_BAD_SRC 8'h09
`define FCS_RES_BAD_SPAN 8'h0A
`define FCS_RES_UNKNOWN 8'hFF
`define FCS_PAGE_BYTES 17'h04000
`define FCS_PERIOD_MIN 16'h000A
`define FCS_PERIOD_MAX 16'h03E8
`define FCS_PROG_PULSE_NS 32'h00001388
`define FCS_ERASE_PULSE_NS 32'h000F4240
`define FCS_BANK0_LO 24'h000000
`define FCS_BANK1_LO 24'h002000
`define FCS_LOWBANK_END 24'h008000
`define FCS_SEG1_BASE 24'h010000
`define FCS_BANK2_LO 24'h018000
`define FCS_BANK3_LO 24'h024000
`define FCS_FLASH_END 24'h030000
`define FCS_WORD_ADDRS 15'h7FFF
`define FCS_BANK_COUNT 16'h0004
`endif

// ==== fcs_pkg.sv ====
// types shared by the flash command sequencer files
// assumes fcs_params.svh for numeric constants
package fcs_pkg;
  typedef struct packed {
    logic [15:0] gr0;
    logic [15:0] gr1;
    logic [15:0] gr2;
    logic [15:0] gr3;
    logic [15:0] gr4;
  } fcs_regs_t;
  typedef struct packed {
    logic [15:0] gr0;
    logic [15:0] gr1;
    logic [15:0] gr2;
    logic [15:0] gr3;
  } fcs_result_t;
  typedef enum logic [7:0] {
    FCS_IDLE = 8'h01,
    FCS_CHECK = 8'h02,
    FCS_PROG = 8'h04,
    FCS_PVERIFY = 8'h08,
    FCS_PREPROG = 8'h10,
    FCS_ERASE = 8'h20,
    FCS_EVERIFY = 8'h40,
    FCS_DONE = 8'h80
  } fcs_state_t;
endpackage

// ==== fcs_map.sv ====
// bank address decoder for the flash array
// assumes 24-bit byte addresses and a low bank segment select level
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_map (
  input wire logic [23:0] byte_addr,
  input wire logic low_bank_segment_select,
  output logic hit,
  output logic [1:0] bank,
  output logic [14:0] word_index
);
  logic [23:0] low_base;
  logic [23:0] rel;
  always_comb
  begin
    low_base = low_bank_segment_select ? `FCS_SEG1_BASE : `FCS_BANK0_LO;
    hit = 1'b0;
    bank = 2'd0;
    rel = 24'h000000;
    // low banks follow the segment select
    if (byte_addr >= low_base && byte_addr < low_base + `FCS_LOWBANK_END)
    begin
      hit = 1'b1; // [R03]
      rel = byte_addr - low_base;
      bank = (rel < `FCS_BANK1_LO) ? 2'd0 : 2'd1;
    end
    // upper banks fixed
    else if (byte_addr >= `FCS_BANK2_LO && byte_addr < `FCS_FLASH_END)
    begin
      hit = 1'b1; // [R04]
      rel = byte_addr - `FCS_BANK2_LO + `FCS_LOWBANK_END;
      bank = (byte_addr < `FCS_BANK3_LO) ? 2'd2 : 2'd3;
    end
    word_index = rel[16:2];
  end
endmodule

// ==== fcs_seq.sv ====
// flash command sequencer: four banks, 32-bit entries
// assumes general registers are valid at the second unlock write
//
// What this block does
// [R01] array entries are 32 bits wide
// [R02] four banks, each erased alone
// [R03] low banks map to segment 0 or 1
// [R04] banks 2 and 3 at fixed addresses
// [R05] software avoids flash reads while busy
// [R06] software blocks interrupts in segment 0 mode
// [R07] protection hides contents, execution still allowed
// [R08] unlock starts check, decode, execute
// [R09] program pulses timed, cells verified
// [R10] erase: preprogram, timed pulses, verify
// [R11] inputs come from registers 0 to 4
// [R12] program codes carry segment low nibble
// [R13] erase needs key and matching bank copies
// [R14] status ignores registers 1 to 3
// [R15] program offsets must be even
// [R16] block span below 16384 bytes
// [R17] source plus span below 16384
// [R18] software keeps source off pages 0,1
// [R19] register 4 holds cpu period ns
// [R20] double: low word then high word
// [R21] software unlocks with paired writes
// [R22] result code returned in register 0
// [R23] failed checks leave flash unchanged
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_seq #(
  parameter int WORDS = 32768,
  parameter int CLK_NS = 20,
  parameter logic [15:0] REVISION = 16'h0010, // arbitrary
  parameter logic [15:0] ID_A = 16'h1234, // arbitrary
  parameter logic [15:0] ID_B = 16'h5678 // arbitrary
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic unlock_first,
  input wire logic unlock_second,
  input wire logic [23:0] unlock_addr,
  input fcs_pkg::fcs_regs_t general_register,
  input wire logic low_bank_segment_select,
  input wire logic vpp_present,
  input wire logic protect_enable,
  input wire logic [23:0] fetch_addr,
  input wire logic fetch_req,
  input wire logic external_view,
  input wire logic [15:0] src_data,
  output logic [23:0] src_addr,
  output logic [31:0] fetch_data,
  output logic fetch_hit,
  output logic busy,
  output logic done,
  output fcs_pkg::fcs_result_t result
);
  localparam int PROG_CYC_I = `FCS_PROG_PULSE_NS / CLK_NS;
  localparam int ERASE_CYC_I = `FCS_ERASE_PULSE_NS / CLK_NS;
  localparam logic [31:0] PROG_CYC = 32'(PROG_CYC_I < 1 ? 1 : PROG_CYC_I);
  localparam logic [31:0] ERASE_CYC = 32'(ERASE_CYC_I < 1 ? 1 : ERASE_CYC_I);

  // ==========================================================
  // storage and decode
  // ==========================================================
  logic [31:0] mem_r [WORDS]; // [R01]
  fcs_pkg::fcs_state_t state_r;
  fcs_pkg::fcs_regs_t cmd_r;
  logic armed_r;
  logic [23:0] arm_addr_r;
  logic [23:0] tgt_r;
  logic [23:0] end_r;
  logic [15:0] src_r;
  logic [1:0] ebank_r;
  logic [14:0] eidx_r;
  logic [31:0] tmr_r;
  logic [7:0] code_r;
  logic [1:0] kind_r;
  logic [1:0] t_bank;
  logic [14:0] t_idx;
  logic t_hit;
  logic [1:0] f_bank;
  logic [14:0] f_idx;
  logic f_hit;
  logic [1:0] e_bank;
  logic [14:0] e_idx;
  logic e_hit;
  logic [23:0] e_addr;
  logic [31:0] wr_word;
  logic [31:0] wr_mask;

  fcs_map u_tgt (
    .byte_addr(tgt_r),
    .low_bank_segment_select(low_bank_segment_select),
    .hit(t_hit),
    .bank(t_bank),
    .word_index(t_idx)
  );
  fcs_map u_fetch (
    .byte_addr(fetch_addr),
    .low_bank_segment_select(low_bank_segment_select),
    .hit(f_hit),
    .bank(f_bank),
    .word_index(f_idx)
  );
  assign e_addr = {9'h000, eidx_r} << 2;
  fcs_map u_erase (
    .byte_addr(e_addr >= `FCS_LOWBANK_END ?
      e_addr - `FCS_LOWBANK_END + `FCS_BANK2_LO :
      e_addr + (low_bank_segment_select ? `FCS_SEG1_BASE : 24'h000000)),
    .low_bank_segment_select(low_bank_segment_select),
    .hit(e_hit),
    .bank(e_bank),
    .word_index(e_idx)
  );

  // ==========================================================
  // parameter checks
  // ==========================================================
  logic [15:0] cmd_code;
  logic [15:0] p1;
  logic [15:0] p2;
  logic [15:0] p3;
  logic [15:0] per;
  logic [3:0] seg;
  logic [16:0] span;
  logic [7:0] chk;
  logic [1:0] kind;
  logic [23:0] seg_base;
  assign cmd_code = cmd_r.gr0;
  assign p1 = cmd_r.gr1;
  assign p2 = cmd_r.gr2;
  assign p3 = cmd_r.gr3;
  assign per = cmd_r.gr4; // [R19]
  assign seg = cmd_code[3:0]; // [R12]
  assign seg_base = {4'h0, seg, 16'h0000};
  assign span = {1'b0, p2} - {1'b0, p1};

  // kind: 0 single/double, 1 block, 2 erase, 3 status
  always_comb
  begin
    chk = `FCS_RES_OK;
    kind = 2'd0;
    if (cmd_code[15:4] == `FCS_CMD_SINGLE_HI ||
        cmd_code[15:4] == `FCS_CMD_DOUBLE_HI) // [R12]
    begin
      kind = 2'd0;
      if (p1[0]) chk = `FCS_RES_BAD_ADDR; // [R15]
      else if (!t_hit) chk = `FCS_RES_BAD_ADDR;
    end
    else if (cmd_code[15:4] == `FCS_CMD_BLOCK_HI)
    begin
      kind = 2'd1;
      if (p1[0] || p2[0] || !t_hit) chk = `FCS_RES_BAD_ADDR; // [R15]
      else if (p2 < p1 || span >= `FCS_PAGE_BYTES)
        chk = `FCS_RES_BAD_SPAN; // [R16]
      else if ({3'b000, p3[13:0]} + span >= `FCS_PAGE_BYTES)
        chk = `FCS_RES_BAD_SRC; // [R17]
      else if (seg_base + {8'h00, p2} >= `FCS_FLASH_END)
        chk = `FCS_RES_BAD_SPAN;
    end
    else if (cmd_code == `FCS_CMD_ERASE)
    begin
      kind = 2'd2;
      if (p1 != `FCS_ERASE_KEY) chk = `FCS_RES_UNKNOWN; // [R13]
      else if (p2 != p3 || p2 >= `FCS_BANK_COUNT)
        chk = `FCS_RES_BAD_BANK; // [R13]
    end
    else if (cmd_code == `FCS_CMD_STATUS)
      kind = 2'd3; // [R14]
    else
      chk = `FCS_RES_UNKNOWN; // [R22]
    if (chk == `FCS_RES_OK && kind != 2'd3)
    begin
      if (per < `FCS_PERIOD_MIN || per > `FCS_PERIOD_MAX)
        chk = `FCS_RES_BAD_PERIOD;
      else if (!vpp_present)
        chk = `FCS_RES_NOVPP;
    end
  end

  // ==========================================================
  // unlock pair
  // ==========================================================
  logic unlock_go;
  assign unlock_go = unlock_second && armed_r && unlock_addr == arm_addr_r &&
    !unlock_addr[0] && state_r == fcs_pkg::FCS_IDLE; // [R08]

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      armed_r <= 1'b0;
      arm_addr_r <= 24'h000000;
    end
    else if (unlock_first)
    begin
      armed_r <= 1'b1;
      arm_addr_r <= unlock_addr;
    end
    else
      armed_r <= 1'b0;
  end

  // ==========================================================
  // sequencer
  // ==========================================================
  logic tmr_done;
  assign tmr_done = tmr_r == 32'h00000000;
  // pulse length scaled by the software period against the real clock
  function automatic logic [31:0] scale(input logic [31:0] base_cyc,
    input logic [15:0] p);
    logic [47:0] prod;
    prod = {16'h0000, base_cyc} * {32'h00000000, p};
    scale = 32'(prod / 48'(CLK_NS));
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= fcs_pkg::FCS_IDLE;
      cmd_r <= '0;
      tgt_r <= 24'h000000;
      end_r <= 24'h000000;
      src_r <= 16'h0000;
      ebank_r <= 2'd0;
      eidx_r <= 15'h0000;
      tmr_r <= 32'h00000000;
      code_r <= `FCS_RES_OK;
      kind_r <= 2'd0;
    end
    else
    begin
      if (!tmr_done) tmr_r <= tmr_r - 32'h00000001;
      unique case (state_r)
        fcs_pkg::FCS_IDLE:
          if (unlock_go)
          begin
            cmd_r <= general_register; // [R11]
            tgt_r <= {4'h0, general_register.gr0[3:0],
              general_register.gr1};
            state_r <= fcs_pkg::FCS_CHECK;
          end
        fcs_pkg::FCS_CHECK:
        begin
          kind_r <= kind;
          code_r <= chk;
          end_r <= seg_base + {8'h00, p2};
          src_r <= p3;
          ebank_r <= p2[1:0];
          eidx_r <= 15'h0000;
          tmr_r <= scale(PROG_CYC, per); // [R09]
          if (chk != `FCS_RES_OK || kind == 2'd3)
            state_r <= fcs_pkg::FCS_DONE; // [R23]
          else if (kind == 2'd2)
            state_r <= fcs_pkg::FCS_PREPROG; // [R10]
          else
            state_r <= fcs_pkg::FCS_PROG;
        end
        fcs_pkg::FCS_PROG:
          if (tmr_done) state_r <= fcs_pkg::FCS_PVERIFY; // [R09]
        fcs_pkg::FCS_PVERIFY:
          if ((mem_r[t_idx] & wr_mask) != (wr_word & wr_mask))
          begin
            code_r <= `FCS_RES_PROG_FAIL; // [R09]
            state_r <= fcs_pkg::FCS_DONE;
          end
          else if (kind_r == 2'd1 && tgt_r < end_r)
          begin
            tgt_r <= tgt_r + 24'h000002;
            src_r <= src_r + 16'h0002;
            tmr_r <= scale(PROG_CYC, per);
            state_r <= fcs_pkg::FCS_PROG;
          end
          else
            state_r <= fcs_pkg::FCS_DONE;
        fcs_pkg::FCS_PREPROG:
          if (eidx_r == `FCS_WORD_ADDRS)
          begin
            tmr_r <= scale(ERASE_CYC, per); // [R10]
            state_r <= fcs_pkg::FCS_ERASE;
          end
          else
            eidx_r <= eidx_r + 15'h0001;
        fcs_pkg::FCS_ERASE:
          if (tmr_done)
          begin
            eidx_r <= 15'h0000;
            state_r <= fcs_pkg::FCS_EVERIFY;
          end
        fcs_pkg::FCS_EVERIFY:
          if (e_hit && e_bank == ebank_r && mem_r[e_idx] != 32'hFFFFFFFF)
          begin
            code_r <= `FCS_RES_ERASE_FAIL; // [R10]
            state_r <= fcs_pkg::FCS_DONE;
          end
          else if (eidx_r == `FCS_WORD_ADDRS)
            state_r <= fcs_pkg::FCS_DONE;
          else
            eidx_r <= eidx_r + 15'h0001;
        fcs_pkg::FCS_DONE:
          state_r <= fcs_pkg::FCS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // array writes
  // ==========================================================
  logic is_double;
  assign is_double = cmd_r.gr0[15:4] == `FCS_CMD_DOUBLE_HI;
  always_comb
  begin
    wr_word = 32'h00000000;
    wr_mask = 32'h00000000;
    if (is_double)
    begin
      wr_word = {p3, p2}; // [R20]
      wr_mask = 32'hFFFFFFFF;
    end
    else if (tgt_r[1])
    begin
      wr_word = {(kind_r == 2'd1 ? src_data : p2), 16'h0000};
      wr_mask = 32'hFFFF0000;
    end
    else
    begin
      wr_word = {16'h0000, (kind_r == 2'd1 ? src_data : p2)};
      wr_mask = 32'h0000FFFF;
    end
  end
  assign src_addr = {8'h00, src_r}; // [R17]

  // bank that owns an array entry
  function automatic logic [1:0] idx_bank(input int i);
    logic [23:0] b;
    b = 24'(i) << 2;
    idx_bank = b < `FCS_BANK1_LO ? 2'd0 : b < `FCS_LOWBANK_END ? 2'd1 :
      b < `FCS_BANK3_LO - `FCS_BANK2_LO + `FCS_LOWBANK_END ? 2'd2 : 2'd3;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    // model starts erased; cells only clear bits when programmed
    if (srst)
      for (int i = 0; i < WORDS; i++)
        mem_r[i] <= 32'hFFFFFFFF;
    else if (state_r == fcs_pkg::FCS_PROG && tmr_done && t_hit)
      mem_r[t_idx] <= mem_r[t_idx] & (wr_word | ~wr_mask); // [R09]
    else if (state_r == fcs_pkg::FCS_PREPROG && e_hit && e_bank == ebank_r)
      mem_r[e_idx] <= 32'h00000000; // [R10]
    else if (state_r == fcs_pkg::FCS_ERASE && tmr_done)
      for (int i = 0; i < WORDS; i++)
        if (idx_bank(i) == ebank_r) mem_r[i] <= 32'hFFFFFFFF; // [R02]
  end

  // ==========================================================
  // outputs
  // ==========================================================
  logic blocked;
  assign blocked = protect_enable && external_view; // [R07]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      fetch_data <= 32'h00000000;
      fetch_hit <= 1'b0;
    end
    else
    begin
      // no array access while an operation runs
      fetch_hit <= fetch_req && f_hit && !busy && !blocked; // [R05]
      fetch_data <= (fetch_req && f_hit && !busy && !blocked) ?
        mem_r[f_idx] : 32'h00000000; // [R07]
    end
  end

  assign busy = state_r != fcs_pkg::FCS_IDLE;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      done <= 1'b0;
      result <= '0;
    end
    else
    begin
      done <= state_r == fcs_pkg::FCS_DONE;
      if (state_r == fcs_pkg::FCS_DONE)
      begin
        result.gr0 <= {8'h00, code_r}; // [R22]
        result.gr1 <= kind_r == 2'd3 ? REVISION :
          kind_r == 2'd1 ? tgt_r[15:0] : p1;
        result.gr2 <= kind_r == 2'd3 ? ID_A : mem_r[t_idx][15:0];
        result.gr3 <= kind_r == 2'd3 ? ID_B : mem_r[t_idx][31:16];
      end
    end
  end
endmodule

// ==== fcs_seq_props.sv ====
// checker for the flash command sequencer ports
// assumes fcs_params.svh and fcs_pkg are compiled first
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_seq_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic unlock_first,
  input wire logic unlock_second,
  input wire logic [23:0] unlock_addr,
  input fcs_pkg::fcs_regs_t general_register,
  input wire logic vpp_present,
  input wire logic protect_enable,
  input wire logic fetch_req,
  input wire logic external_view,
  input wire logic fetch_hit,
  input wire logic busy,
  input wire logic done,
  input fcs_pkg::fcs_result_t result
);
  // ==========================================
  // helper logic
  logic first_r;
  logic [23:0] addr_r;
  logic go;
  logic unk;
  logic [15:0] cmd;
  logic [15:0] per;
  assign cmd = general_register.gr0;
  assign per = general_register.gr4;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      first_r <= 1'b0;
    else
      first_r <= unlock_first;
  end
  always_ff @(posedge sys_clk)
  begin
    addr_r <= unlock_addr;
  end
  // paired unlock on one even bank 2 or 3 address while idle
  assign go = first_r && unlock_second && !busy && unlock_addr == addr_r
    && !unlock_addr[0] && unlock_addr >= `FCS_BANK2_LO
    && unlock_addr < `FCS_FLASH_END;
  assign unk = cmd[15:4] != `FCS_CMD_SINGLE_HI
    && cmd[15:4] != `FCS_CMD_DOUBLE_HI && cmd[15:4] != `FCS_CMD_BLOCK_HI
    && cmd != `FCS_CMD_ERASE && cmd != `FCS_CMD_STATUS
    && per >= `FCS_PERIOD_MIN && per <= `FCS_PERIOD_MAX && vpp_present;
  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    srst |=> !busy && !done) else $error("not idle after reset");
  AST_GO_BUSY: assert property (
    go |=> busy) else $error("no busy after unlock");
  AST_FETCH_BUSY: assert property (
    busy && fetch_req |=> !fetch_hit) else $error("fetch served while busy");
  AST_PROTECT_VIEW: assert property (
    protect_enable && external_view && fetch_req |=> !fetch_hit)
    else $error("protected view served");
  AST_DONE_PULSE: assert property (
    done |=> !done) else $error("done longer than one cycle");
  AST_RESULT_HOLD: assert property (
    !done && !$past(srst) |-> $stable(result)) else $error("result moved");
  AST_DONE_AFTER_BUSY: assert property (
    done |-> !busy && $past(busy)) else $error("done without busy");
  AST_UNKNOWN_CMD: assert property (
    go && unk |-> ##[1:4] (done && result.gr0[7:0] == `FCS_RES_UNKNOWN))
    else $error("unknown command not refused");
  // ==========================================
  // covers
  C_OK: cover property (done && result.gr0[7:0] == `FCS_RES_OK);
  C_BUSY_FETCH: cover property (busy && fetch_req);
  C_PROT: cover property (protect_enable && external_view && fetch_req);
endmodule
bind fcs_seq fcs_seq_props i_props (.sys_clk, .srst, .unlock_first,
  .unlock_second, .unlock_addr, .general_register, .vpp_present,
  .protect_enable, .fetch_req, .external_view, .fetch_hit, .busy, .done,
  .result);

// ==== flash_command_sequencer_tb.sv ====
// testbench for the flash command sequencer
// assumes fcs_pkg, fcs_seq and the checker are compiled first
`timescale 1ns/100ps
module flash_command_sequencer_tb;
  localparam logic [15:0] REV = 16'h00A1; // arbitrary
  localparam logic [15:0] IDA = 16'h0B2C; // arbitrary
  localparam logic [15:0] IDB = 16'h0D3E; // arbitrary
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic unlock_first = 1'b0;
  logic unlock_second = 1'b0;
  logic [23:0] unlock_addr = 24'h018000;
  fcs_pkg::fcs_regs_t general_register = '0;
  logic low_bank_segment_select = 1'b1;
  logic vpp_present = 1'b1;
  logic protect_enable = 1'b0;
  logic external_view = 1'b0;
  logic [23:0] fetch_addr = 24'h000000;
  logic fetch_req = 1'b0;
  logic [15:0] src_data;
  logic [23:0] src_addr;
  logic [31:0] fetch_data;
  logic fetch_hit;
  logic busy;
  logic done;
  fcs_pkg::fcs_result_t result;
  int mismatches = 0;
  int checked = 0;
  logic [87:0] tbl [9] = '{
    88'h1234_0000_0000_0000_0014_FF, 88'h55A1_0224_AAAA_0000_0009_05,
    88'h55A1_0224_AAAA_0000_03E9_05, 88'h55A1_0225_AAAA_0000_0014_04,
    88'hDD41_0223_AAAA_BBBB_0014_04, 88'hEEEE_5555_0002_0003_0014_07,
    88'hEEEE_5555_0004_0004_0014_07, 88'hEEEE_5554_0002_0002_0014_FF,
    88'hAA51_0000_4000_0010_0014_0A};
  // source memory seen by block programming
  assign src_data = src_addr[15:0] ^ 16'hA5A5;
  always #10 sys_clk = ~sys_clk;
  fcs_seq #(.REVISION(REV), .ID_A(IDA), .ID_B(IDB)) i_dut (.sys_clk,
    .srst, .unlock_first, .unlock_second, .unlock_addr, .general_register,
    .low_bank_segment_select, .vpp_present, .protect_enable, .fetch_addr,
    .fetch_req, .external_view, .src_data, .src_addr, .fetch_data,
    .fetch_hit, .busy, .done, .result);
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input logic [87:0] t);
    int n;
    @(negedge sys_clk);
    general_register = t[87:8];
    unlock_first = 1'b1;
    @(negedge sys_clk);
    unlock_first = 1'b0;
    unlock_second = 1'b1;
    @(negedge sys_clk);
    unlock_second = 1'b0;
    chk(32'(busy), 32'h1);
    for (n = 0; n < 95000 && done !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 95000)
    begin
      mismatches++;
      wrap_up();
    end
    chk(32'(result.gr0[7:0]), 32'(t[7:0]));
  endtask
  task automatic fetch(input logic [23:0] a, input logic hit,
    input logic [31:0] d);
    @(negedge sys_clk);
    fetch_addr = a;
    fetch_req = 1'b1;
    @(negedge sys_clk);
    fetch_req = 1'b0;
    chk(32'(fetch_hit), 32'(hit));
    if (hit)
      chk(fetch_data, d);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk(32'({busy, done}), 32'h0);
    run(88'h7777_1111_2222_3333_0014_00);
    chk(32'({result.gr1, result.gr2}), {REV, IDA});
    chk(32'(result.gr3), 32'(IDB));
    $display("test status ends");
    fork
      run(88'hDD41_0224_3456_4567_0014_00);
      begin
        repeat (4) @(negedge sys_clk);
        fetch(24'h010224, 1'b0, 32'h0);
      end
    join
    chk({result.gr3, result.gr2}, 32'h45673456);
    fetch(24'h010224, 1'b1, 32'h45673456);
    protect_enable = 1'b1;
    external_view = 1'b1;
    fetch(24'h010224, 1'b0, 32'h0);
    external_view = 1'b0;
    fetch(24'h010224, 1'b1, 32'h45673456);
    protect_enable = 1'b0;
    $display("test double word ends");
    foreach (tbl[i])
      run(tbl[i]);
    fetch(24'h010224, 1'b1, 32'h45673456);
    $display("test refusals ends");
    low_bank_segment_select = 1'b0;
    run(88'hDD41_8000_1357_2468_0014_00);
    fetch(24'h018000, 1'b1, 32'h24681357);
    vpp_present = 1'b0;
    run(88'hDD41_8008_0001_0002_0014_02);
    vpp_present = 1'b1;
    $display("test bank map ends");
    run(88'hAA51_8100_8104_8000_0014_00);
    fetch(24'h018100, 1'b1, 32'h25A725A5);
    fetch(24'h018104, 1'b1, 32'hFFFF25A1);
    $display("test block ends");
    run(88'hEEEE_5555_0000_0000_000A_00);
    fetch(24'h018000, 1'b1, 32'h24681357);
    fetch(24'h000224, 1'b1, 32'hFFFFFFFF);
    $display("test erase ends");
    wrap_up();
  end
endmodule
